// ===== logic/mac_defines.svh
// Timing and layout constants for the module alert and control block.
// Assumes a 200 MHz management clock; included by its bare name.
`ifndef MAC_DEFINES_SVH
`define MAC_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock rate
// ----------------------------------------------------------------------
`define MAC_CLK_PERIOD_PS 5000
`define MAC_CYC_PER_MS (1000000000 / `MAC_CLK_PERIOD_PS)

// ----------------------------------------------------------------------
// Times as printed, and derived cycle counts
// ----------------------------------------------------------------------
`define MAC_T_RESET_MIN_US 2
`define MAC_RESET_MIN_CYC \
   ((`MAC_T_RESET_MIN_US * 1000000 + `MAC_CLK_PERIOD_PS - 1) / `MAC_CLK_PERIOD_PS)
`define MAC_T_INIT_MS 2000
`define MAC_INIT_CYC (`MAC_T_INIT_MS * `MAC_CYC_PER_MS)

// ----------------------------------------------------------------------
// Flag layout and reset values
// ----------------------------------------------------------------------
`define MAC_NUM_FLAGS 8
`define MAC_FLAG_RX_LOS 0
`define MAC_FLAG_TX_FAULT 1
`define MAC_MASK_RESET 8'h00
`define MAC_PDOWN_RESET 1'b0
`define MAC_PENDING_RESET 1'b1
// Pin synchroniser reset: reset released, deselected, no low-power request,
// so that leaving srst shows no false low-power entry
`define MAC_PIN_IDLE 3'h6

`endif

// ===== logic/mac_pkg.sv
// Types shared by the module alert and control block.
// Assumes mac_defines.svh supplies the widths.
`include "mac_defines.svh"

package mac_pkg;

   typedef logic [`MAC_NUM_FLAGS-1:0] mac_flags_t;

   typedef enum logic [1:0] {
      MAC_ST_INIT,
      MAC_ST_RUN,
      MAC_ST_RST_LOW
   } mac_state_t;

endpackage

// ===== logic/mac_toggle_sync.sv
// Event crossing between two clock domains by a toggle and a
// two-flop synchroniser. Assumes events in the source domain are spaced
// by several destination clocks.
`timescale 1ns/100ps

module mac_toggle_sync (
   // Source side
   input wire logic src_clk,
   input wire logic src_rst,
   input wire logic src_pulse,
   // Destination side
   input wire logic dst_clk,
   input wire logic dst_rst,
   output logic dst_pulse
);

   logic src_tgl;
   logic next_src_tgl;
   logic meta;
   logic sync;
   logic prev;

   always_comb begin
      next_src_tgl = src_tgl ^ src_pulse;
   end

   always_ff @(posedge src_clk) begin
      if (src_rst) begin
         src_tgl <= 1'b0;
      end else begin
         src_tgl <= next_src_tgl;
      end
   end

   // The first flop is read only by the second
   always_ff @(posedge dst_clk) begin
      if (dst_rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= src_tgl;
         sync <= meta;
         prev <= sync;
      end
   end

   assign dst_pulse = sync ^ prev;

endmodule

// ===== logic/mac_alert_ctrl.sv
// Alert, flag, reset, select and low-power control of a pluggable module.
// Assumes an outside serial engine on the bus clock reports completed
// flag reads and control writes; pins arrive asynchronously.
`timescale 1ns/100ps
`include "mac_defines.svh"

module mac_alert_ctrl
   import mac_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = `MAC_INIT_CYC
) (
   // Management clock and power-on reset
   input wire logic clk,
   input wire logic srst,
   // Host sideband pins
   input wire logic module_reset_n,
   input wire logic module_select_n,
   input wire logic low_power_request,
   output logic fault_alert_n_o,
   output logic fault_alert_n_oe,
   // Monitored conditions, asynchronous
   input wire logic [`MAC_NUM_FLAGS-1:0] cond_in,
   // Serial engine side, on the bus clock
   input wire logic link_clk,
   input wire logic link_rd_done,
   input wire logic [`MAC_NUM_FLAGS:0] link_rd_clear,
   input wire logic link_wr_done,
   input wire logic [`MAC_NUM_FLAGS-1:0] link_wr_mask,
   input wire logic link_wr_power_down,
   output logic link_respond,
   // Status towards the serial engine's read data
   output logic [`MAC_NUM_FLAGS-1:0] flags,
   output logic [`MAC_NUM_FLAGS-1:0] mask,
   output logic power_down_bit,
   output logic monitor_pending,
   // Power control
   output logic low_power
);

   // ----------------------------------------------------------------------
   // Local widths and limits
   // ----------------------------------------------------------------------
   localparam int unsigned INIT_W = $clog2(INIT_CYCLES + 1);
   localparam int unsigned RST_W = $clog2(`MAC_RESET_MIN_CYC + 1);
   localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);
   localparam logic [RST_W-1:0] RST_MIN = RST_W'(`MAC_RESET_MIN_CYC);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic [`MAC_NUM_FLAGS-1:0] cond_meta;
   logic [`MAC_NUM_FLAGS-1:0] cond_sync;
   logic reset_pin_n;
   logic select_pin_n;
   logic lp_pin;

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_meta <= `MAC_PIN_IDLE;
         pin_sync <= `MAC_PIN_IDLE;
         cond_meta <= '0;
         cond_sync <= '0;
      end else begin
         pin_meta <= {module_reset_n, module_select_n, low_power_request};
         pin_sync <= pin_meta;
         cond_meta <= cond_in;
         cond_sync <= cond_meta;
      end
   end

   assign reset_pin_n = pin_sync[2];
   assign select_pin_n = pin_sync[1];
   assign lp_pin = pin_sync[0];

   // ----------------------------------------------------------------------
   // Link domain: local reset and event capture
   // ----------------------------------------------------------------------
   // The bus clock stops between frames, so captured data is simply held
   // until the next frame; the management side samples it after the event.
   logic link_rst_meta;
   logic link_rst;
   logic [`MAC_NUM_FLAGS:0] link_clr_hold;
   logic [`MAC_NUM_FLAGS-1:0] link_mask_hold;
   logic link_pdown_hold;
   logic [`MAC_NUM_FLAGS:0] next_link_clr_hold;
   logic [`MAC_NUM_FLAGS-1:0] next_link_mask_hold;
   logic next_link_pdown_hold;
   logic resp_meta;
   logic resp_sync;
   logic respond_en;

   always_ff @(posedge link_clk) begin
      link_rst_meta <= srst;
      link_rst <= link_rst_meta;
   end

   always_comb begin
      next_link_clr_hold = link_clr_hold;
      next_link_mask_hold = link_mask_hold;
      next_link_pdown_hold = link_pdown_hold;
      if (link_rd_done) begin
         next_link_clr_hold = link_rd_clear;
      end
      if (link_wr_done) begin
         next_link_mask_hold = link_wr_mask;
         next_link_pdown_hold = link_wr_power_down;
      end
   end

   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         link_clr_hold <= '0;
         link_mask_hold <= `MAC_MASK_RESET;
         link_pdown_hold <= `MAC_PDOWN_RESET;
         resp_meta <= 1'b0;
         resp_sync <= 1'b0;
      end else begin
         link_clr_hold <= next_link_clr_hold;
         link_mask_hold <= next_link_mask_hold;
         link_pdown_hold <= next_link_pdown_hold;
         resp_meta <= respond_en;
         resp_sync <= resp_meta;
      end
   end

   // Bus answers are gated by select; deselect silences the engine
   assign link_respond = resp_sync;

   // ----------------------------------------------------------------------
   // Event crossings into the management domain
   // ----------------------------------------------------------------------
   logic rd_evt;
   logic wr_evt;

   mac_toggle_sync u_rd_sync (
      .src_clk(link_clk),
      .src_rst(link_rst),
      .src_pulse(link_rd_done),
      .dst_clk(clk),
      .dst_rst(srst),
      .dst_pulse(rd_evt)
   );

   mac_toggle_sync u_wr_sync (
      .src_clk(link_clk),
      .src_rst(link_rst),
      .src_pulse(link_wr_done),
      .dst_clk(clk),
      .dst_rst(srst),
      .dst_pulse(wr_evt)
   );

   // ----------------------------------------------------------------------
   // Reset pulse qualification and initialisation sequence
   // ----------------------------------------------------------------------
   mac_state_t state;
   mac_state_t next_state;
   logic [INIT_W-1:0] init_cnt;
   logic [INIT_W-1:0] next_init_cnt;
   logic [RST_W-1:0] low_cnt;
   logic [RST_W-1:0] next_low_cnt;
   logic init_done;
   logic soft_reset;

   always_comb begin
      next_state = state;
      next_init_cnt = init_cnt;
      next_low_cnt = low_cnt;
      init_done = 1'b0;
      soft_reset = 1'b0;
      unique case (state)
         MAC_ST_INIT: begin
            if (!reset_pin_n) begin
               next_state = MAC_ST_RST_LOW;
               next_low_cnt = RST_W'(1);
            end else if (init_cnt == INIT_LAST) begin
               next_state = MAC_ST_RUN;
               init_done = 1'b1;
            end else begin
               next_init_cnt = init_cnt + INIT_W'(1);
            end
         end
         MAC_ST_RUN: begin
            if (!reset_pin_n) begin
               next_state = MAC_ST_RST_LOW;
               next_low_cnt = RST_W'(1);
            end
         end
         MAC_ST_RST_LOW: begin
            if (!reset_pin_n) begin
               if (low_cnt != RST_MIN) begin
                  next_low_cnt = low_cnt + RST_W'(1);
               end
            end else if (low_cnt == RST_MIN) begin
               // Long enough: restart init from the rising edge
               next_state = MAC_ST_INIT;
               next_init_cnt = '0;
               soft_reset = 1'b1;
            end else begin
               // A glitch shorter than the minimum is not a reset
               next_state = monitor_pending ? MAC_ST_INIT : MAC_ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= MAC_ST_INIT;
         init_cnt <= '0;
         low_cnt <= '0;
      end else begin
         state <= next_state;
         init_cnt <= next_init_cnt;
         low_cnt <= next_low_cnt;
      end
   end

   // ----------------------------------------------------------------------
   // Settings written by the host
   // ----------------------------------------------------------------------
   logic [`MAC_NUM_FLAGS-1:0] next_mask;
   logic next_power_down_bit;

   always_comb begin
      next_mask = mask;
      next_power_down_bit = power_down_bit;
      if (soft_reset) begin
         next_mask = `MAC_MASK_RESET;
         next_power_down_bit = `MAC_PDOWN_RESET;
      end else if (wr_evt) begin
         // Event lands after the write's stop bit; one cycle to apply
         next_mask = link_mask_hold;
         next_power_down_bit = link_pdown_hold;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mask <= `MAC_MASK_RESET;
         power_down_bit <= `MAC_PDOWN_RESET;
      end else begin
         mask <= next_mask;
         power_down_bit <= next_power_down_bit;
      end
   end

   // ----------------------------------------------------------------------
   // Latched flags and completion alert
   // ----------------------------------------------------------------------
   // Clear-on-read: the read names the flags it returned. A condition
   // still present in the clearing cycle keeps its flag set.
   logic [`MAC_NUM_FLAGS-1:0] next_flags;
   logic next_monitor_pending;
   logic done_alert;
   logic next_done_alert;
   logic [`MAC_NUM_FLAGS-1:0] rd_clr;

   assign rd_clr = rd_evt ? link_clr_hold[`MAC_NUM_FLAGS-1:0] : '0;

   always_comb begin
      next_flags = (flags & ~rd_clr) | cond_sync;
      next_monitor_pending = monitor_pending;
      next_done_alert = done_alert;
      if (rd_evt && link_clr_hold[`MAC_NUM_FLAGS]) begin
         next_done_alert = 1'b0;
      end
      if (soft_reset) begin
         next_flags = cond_sync;
         next_monitor_pending = `MAC_PENDING_RESET;
         next_done_alert = 1'b0;
      end else if (init_done) begin
         next_monitor_pending = 1'b0;
         next_done_alert = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flags <= '0;
         monitor_pending <= `MAC_PENDING_RESET;
         done_alert <= 1'b0;
      end else begin
         flags <= next_flags;
         monitor_pending <= next_monitor_pending;
         done_alert <= next_done_alert;
      end
   end

   // ----------------------------------------------------------------------
   // Alert pin, select gating and power level
   // ----------------------------------------------------------------------
   // Flags gathered during init are held back so that the first alert the
   // host sees is the completion one.
   logic next_alert_oe;
   logic alert_oe_q;
   logic next_respond_en;
   logic next_low_power;

   always_comb begin
      next_alert_oe = done_alert | (!monitor_pending && |(flags & ~mask));
      next_respond_en = !select_pin_n && !monitor_pending;
      next_low_power = lp_pin | power_down_bit;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         alert_oe_q <= 1'b0;
         respond_en <= 1'b0;
         low_power <= 1'b0;
      end else begin
         alert_oe_q <= next_alert_oe;
         respond_en <= next_respond_en;
         low_power <= next_low_power;
      end
   end

   // Open collector: only ever drives low
   assign fault_alert_n_o = 1'b0;
   assign fault_alert_n_oe = alert_oe_q;

endmodule

// ===== verification/mac_alert_ctrl_chk.sv
// Concurrent checks on the ports of the alert and control block.
// Assumes clk and link_clk are both reset by srst; link_clk may stop.
`timescale 1ns/100ps
`include "mac_defines.svh"

module mac_alert_ctrl_chk #(
   parameter int unsigned INIT_CYCLES = `MAC_INIT_CYC
) (
   // Clocks and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic link_clk,
   // Pins
   input wire logic module_reset_n,
   input wire logic module_select_n,
   input wire logic low_power_request,
   input wire logic fault_alert_n_o,
   input wire logic fault_alert_n_oe,
   input wire logic [`MAC_NUM_FLAGS-1:0] cond_in,
   // Link side
   input wire logic link_rd_done,
   input wire logic [`MAC_NUM_FLAGS:0] link_rd_clear,
   input wire logic link_wr_done,
   input wire logic [`MAC_NUM_FLAGS-1:0] link_wr_mask,
   input wire logic link_wr_power_down,
   input wire logic link_respond,
   // Status
   input wire logic [`MAC_NUM_FLAGS-1:0] flags,
   input wire logic [`MAC_NUM_FLAGS-1:0] mask,
   input wire logic power_down_bit,
   input wire logic monitor_pending,
   input wire logic low_power
);
   // -----------------------------------------------------------------
   // Init length counter
   // -----------------------------------------------------------------
   int unsigned init_cnt;
   int unsigned next_init_cnt;
   always_comb begin
      next_init_cnt = monitor_pending ? init_cnt + 1 : 0;
   end
   always_ff @(posedge clk) begin
      init_cnt <= srst ? 0 : next_init_cnt;
   end

   // -----------------------------------------------------------------
   // Sequences and properties
   // -----------------------------------------------------------------
   // Four link edges cover the pin synchroniser plus the link flops; the
   // selected side needs two more, as the link reset lingers after srst
   sequence s_sel_off;
      module_select_n [*4];
   endsequence
   sequence s_sel_on;
      (!module_select_n && !monitor_pending) [*6];
   endsequence
   property p_set(logic c, logic f);
      @(posedge clk) disable iff (srst) $rose(c) && module_reset_n |-> ##[1:8] f;
   endproperty

   open_drain_a: assert property (@(posedge clk) disable iff (srst) !fault_alert_n_o)
      else $error("alert pin drives a high level");
   rx_los_set_a: assert property (p_set(cond_in[0], flags[0]))
      else $error("signal loss flag late");
   tx_fault_set_a: assert property (p_set(cond_in[1], flags[1]))
      else $error("transmit fault flag late");
   other_set_a: assert property (p_set(cond_in[5], flags[5]))
      else $error("monitored flag late");
   alert_follow_a: assert property (@(posedge clk) disable iff (srst)
      ((|(flags & ~mask)) && !monitor_pending && module_reset_n) [*3] |-> fault_alert_n_oe)
      else $error("alert not pulled for unmasked flag");
   pending_done_a: assert property (@(posedge clk) disable iff (srst)
      $fell(monitor_pending) |=> fault_alert_n_oe)
      else $error("no alert at end of init");
   init_bound_a: assert property (@(posedge clk) disable iff (srst)
      init_cnt <= INIT_CYCLES + 8)
      else $error("init runs too long");
   select_off_a: assert property (@(posedge link_clk) disable iff (srst)
      s_sel_off |-> !link_respond)
      else $error("answering while deselected");
   select_on_a: assert property (@(posedge link_clk) disable iff (srst)
      s_sel_on |-> link_respond)
      else $error("not answering while selected");
   lp_on_a: assert property (@(posedge clk) disable iff (srst)
      (low_power_request || power_down_bit) [*5] |-> low_power)
      else $error("low power not entered");
   lp_off_a: assert property (@(posedge clk) disable iff (srst)
      !(low_power_request || power_down_bit) [*5] |-> !low_power)
      else $error("low power not left");
   flag_clear_a: assert property (@(posedge link_clk) disable iff (srst)
      link_rd_done && link_rd_clear[0] && !cond_in[0] |-> ##2 !flags[0])
      else $error("flag not cleared by read");
endmodule

bind mac_alert_ctrl mac_alert_ctrl_chk #(.INIT_CYCLES(INIT_CYCLES)) chk (
   .clk(clk), .srst(srst), .link_clk(link_clk), .module_reset_n(module_reset_n),
   .module_select_n(module_select_n), .low_power_request(low_power_request),
   .fault_alert_n_o(fault_alert_n_o), .fault_alert_n_oe(fault_alert_n_oe), .cond_in(cond_in),
   .link_rd_done(link_rd_done), .link_rd_clear(link_rd_clear), .link_wr_done(link_wr_done),
   .link_wr_mask(link_wr_mask), .link_wr_power_down(link_wr_power_down),
   .link_respond(link_respond), .flags(flags), .mask(mask), .power_down_bit(power_down_bit),
   .monitor_pending(monitor_pending), .low_power(low_power));

// ===== verification/mac_host_model.sv
// Host-side serial engine model: reports finished status reads and control writes.
// Assumes the caller spaces frames; the link clock only runs inside frames.
`timescale 1ns/100ps
`include "mac_defines.svh"

module mac_host_model (
   // Link clock, stopped between frames
   output logic link_clk,
   // Finished transfers
   output logic link_rd_done,
   output logic [`MAC_NUM_FLAGS:0] link_rd_clear,
   output logic link_wr_done,
   output logic [`MAC_NUM_FLAGS-1:0] link_wr_mask,
   output logic link_wr_power_down
);
   initial begin
      link_clk = 1'b0;
      link_rd_done = 1'b0;
      link_wr_done = 1'b0;
      link_rd_clear = '0;
      link_wr_mask = '0;
      link_wr_power_down = 1'b0;
   end

   task tick(input int n);
      repeat (n) begin
         #80 link_clk = 1'b1;
         #80 link_clk = 1'b0;
      end
   endtask

   // Strobes drop and data is inverted once released so stale values never look valid
   task xfer(input logic rd, input logic [8:0] clr, input logic wr, input logic [7:0] msk,
             input logic pd);
      #1;
      link_rd_done = rd;
      link_rd_clear = clr;
      link_wr_done = wr;
      link_wr_mask = msk;
      link_wr_power_down = pd;
      // Release just after the sampling rising edge, not on the falling one
      #80 link_clk = 1'b1;
      #1;
      link_rd_done = 1'b0;
      link_wr_done = 1'b0;
      link_rd_clear = ~clr;
      link_wr_mask = ~msk;
      link_wr_power_down = ~pd;
      #79 link_clk = 1'b0;
      tick(2);
   endtask
endmodule

// ===== verification/mac_alert_ctrl_bench.sv
// Self-checking bench for the alert and control block.
// Assumes the checker is bound by its own file and a short init count.
`timescale 1ns/100ps
`include "mac_defines.svh"
`define MAC_CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module mac_alert_ctrl_bench;
   localparam int unsigned INIT = 50;
   localparam int NF = `MAC_NUM_FLAGS;
   logic clk, srst, module_reset_n, module_select_n, low_power_request;
   logic [NF-1:0] cond_in, flags, mask, link_wr_mask;
   logic [NF:0] link_rd_clear;
   logic fault_alert_n_o, fault_alert_n_oe, link_respond, power_down_bit, monitor_pending;
   logic low_power, link_clk, link_rd_done, link_wr_done, link_wr_power_down, alert_wire;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;

   // Board pull-up on the open-collector alert line
   assign alert_wire = fault_alert_n_oe ? fault_alert_n_o : 1'b1;

   mac_alert_ctrl #(.INIT_CYCLES(INIT)) uut (
      .clk(clk), .srst(srst), .module_reset_n(module_reset_n),
      .module_select_n(module_select_n), .low_power_request(low_power_request),
      .fault_alert_n_o(fault_alert_n_o), .fault_alert_n_oe(fault_alert_n_oe),
      .cond_in(cond_in), .link_clk(link_clk), .link_rd_done(link_rd_done),
      .link_rd_clear(link_rd_clear), .link_wr_done(link_wr_done), .link_wr_mask(link_wr_mask),
      .link_wr_power_down(link_wr_power_down), .link_respond(link_respond), .flags(flags),
      .mask(mask), .power_down_bit(power_down_bit), .monitor_pending(monitor_pending),
      .low_power(low_power));
   mac_host_model host (
      .link_clk(link_clk), .link_rd_done(link_rd_done), .link_rd_clear(link_rd_clear),
      .link_wr_done(link_wr_done), .link_wr_mask(link_wr_mask),
      .link_wr_power_down(link_wr_power_down));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task close_out;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         errors++;
         close_out();
      end
   end

   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task wait_pend;
      int k;
      k = 0;
      while (monitor_pending !== 1'b0 && k < 200) begin
         cyc(1);
         k++;
      end
      `MAC_CHK("init done", 1'b0, monitor_pending)
      cyc(2);
   endtask
   task rd(input logic [8:0] c);
      host.xfer(1'b1, c, 1'b0, 8'h00, 1'b0);
      cyc(10);
   endtask
   task wr(input logic [7:0] m, input logic pd);
      host.xfer(1'b0, 9'h000, 1'b1, m, pd);
      cyc(10);
   endtask

   initial begin
      srst = 1'b1;
      module_reset_n = 1'b1;
      module_select_n = 1'b0;
      low_power_request = 1'b0;
      cond_in = '0;
      cyc(6);
      // Link flops only reset if the link clock ticks during srst
      host.tick(3);
      cyc(1);
      srst = 1'b0;
      wait_pend();
      `MAC_CHK("alert after init", 1'b0, alert_wire)
      `MAC_CHK("mask default", 8'h00, mask)
      `MAC_CHK("pdown default", 1'b0, power_down_bit)
      host.tick(4);
      `MAC_CHK("respond", 1'b1, link_respond)
      rd(9'h100);
      `MAC_CHK("alert released", 1'b1, alert_wire)
      $display("test init done");
      for (int i = 0; i < NF; i++) begin
         cond_in[i] = 1'b1;
         cyc(8);
         `MAC_CHK("flag set", 1'b1, flags[i])
         `MAC_CHK("alert set", 1'b0, alert_wire)
         rd(9'h001 << i);
         `MAC_CHK("set wins", 1'b1, flags[i])
         cond_in[i] = 1'b0;
         cyc(20);
         `MAC_CHK("flag latched", 1'b1, flags[i])
         rd(9'h001 << i);
         `MAC_CHK("flag cleared", 8'h00, flags)
         `MAC_CHK("alert cleared", 1'b1, alert_wire)
      end
      $display("test flags done");
      cond_in[2] = 1'b1;
      cyc(8);
      cond_in[2] = 1'b0;
      wr(8'h04, 1'b0);
      `MAC_CHK("mask reg", 8'h04, mask)
      `MAC_CHK("masked alert", 1'b1, alert_wire)
      wr(8'h00, 1'b0);
      `MAC_CHK("unmasked alert", 1'b0, alert_wire)
      rd(9'h004);
      $display("test mask done");
      low_power_request = 1'b1;
      cyc(6);
      `MAC_CHK("lp pin", 1'b1, low_power)
      low_power_request = 1'b0;
      cyc(6);
      `MAC_CHK("lp pin off", 1'b0, low_power)
      wr(8'h00, 1'b1);
      `MAC_CHK("pdown", 1'b1, low_power)
      wr(8'h00, 1'b0);
      `MAC_CHK("pdown off", 1'b0, low_power)
      module_select_n = 1'b1;
      host.tick(4);
      `MAC_CHK("deselected", 1'b0, link_respond)
      cyc(1);
      module_select_n = 1'b0;
      host.tick(4);
      `MAC_CHK("reselected", 1'b1, link_respond)
      $display("test power select done");
      wr(8'hFF, 1'b1);
      module_reset_n = 1'b0;
      cyc(100);
      module_reset_n = 1'b1;
      cyc(10);
      `MAC_CHK("short pulse", 8'hFF, mask)
      module_reset_n = 1'b0;
      cyc(420);
      module_reset_n = 1'b1;
      cyc(8);
      `MAC_CHK("reset mask", 8'h00, mask)
      `MAC_CHK("reset pdown", 1'b0, power_down_bit)
      `MAC_CHK("pending", 1'b1, monitor_pending)
      wait_pend();
      `MAC_CHK("alert after reset", 1'b0, alert_wire)
      $display("test reset done");
      close_out();
   end
endmodule
